/* pom_pkg.sv */
// Constants for the pin output multiplexer: register indices, field positions,
// selector codes and reset values.
// Assumes the register bus puts each 16-bit register in its own aligned 32-bit word.
package pom_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [13:0] POM_IDX_MUX_CTRL   = 14'h0463;
    localparam logic [13:0] POM_IDX_STRAP_LO   = 14'h0467;
    localparam logic [13:0] POM_IDX_STRAP_HI   = 14'h0468;
    localparam logic [13:0] POM_IDX_IND_CFG    = 14'h0469;
    localparam int          POM_IDX_LSB        = 2;

    localparam logic [15:0] POM_MUX_CTRL_RST   = 16'h0000;
    localparam logic [15:0] POM_IND_CFG_RST    = 16'h0000;
    localparam logic [15:0] POM_IND_CFG_MASK   = 16'h0777;
    localparam logic [15:0] POM_ZERO16         = 16'h0000;

    // Multiplexer control fields
    localparam int POM_GP_SRC_LSB  = 13;
    localparam int POM_GP_SEL_LSB  = 10;
    localparam int POM_TXERR_BIT   = 9;
    localparam int POM_CO_DIV_BIT  = 8;
    localparam int POM_CO_SRC_LSB  = 4;
    localparam int POM_CO_INV_BIT  = 3;
    localparam int POM_CO_SEL_LSB  = 0;

    // Indicator configuration fields
    localparam int POM_C_POL_BIT   = 10;
    localparam int POM_C_VAL_BIT   = 9;
    localparam int POM_C_FRC_BIT   = 8;
    localparam int POM_B_POL_BIT   = 6;
    localparam int POM_B_VAL_BIT   = 5;
    localparam int POM_B_FRC_BIT   = 4;
    localparam int POM_A_POL_BIT   = 2;
    localparam int POM_A_VAL_BIT   = 1;
    localparam int POM_A_FRC_BIT   = 0;

    // Pin selector codes
    localparam logic [2:0] POM_SEL_IND    = 3'h0;
    localparam logic [2:0] POM_SEL_CLK    = 3'h1;
    localparam logic [2:0] POM_SEL_IRQ    = 3'h2;
    localparam logic [2:0] POM_SEL_ZERO   = 3'h3;
    localparam logic [2:0] POM_SEL_CONST0 = 3'h6;
    localparam logic [2:0] POM_SEL_CONST1 = 3'h7;

    // Clock source codes that exist: 0..6 and 8..12
    localparam logic [15:0] POM_CLK_VALID  = 16'h1F7F;
    localparam logic [3:0]  POM_CLK_LAST_COMMON = 4'h6;
    localparam int          POM_CLK_SRCS   = 16;
    localparam int          POM_STRAP_W    = 10;

endpackage

/* pom_pin_mux.sv */
// Output multiplexer for the general-purpose pin, the clock-output pin and the
// indicator A and C pins, with strap capture and an Avalon-MM register slave.
// Assumes all inputs, clock sources included, are synchronous to mclk_in.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE1: The general-purpose pin shows indicator B, the muxed clock, the interrupt or a constant per its 3-bit selector.
// RULE2: The clock-output pin shows the same choice of sources under its own 3-bit selector.
// RULE3: A 3-bit field picks one of seven clocks for the general-purpose pin when it carries a clock.
// RULE4: A 4-bit field picks the clock for the clock-output pin, codes 0 to 6 matching the general-purpose choices.
// RULE5: Codes 8 to 12 of that field add the mode reference, RMII receive and transmit, MII receive and RGMII receive clocks.
// RULE6: A divide bit makes the clock-output pin carry its source at half rate.
// RULE7: An invert bit makes the clock-output pin carry its source inverted.
// RULE8: With the reuse bit set, indicator C's pin becomes the MII transmit-error input.
// RULE9: A read-only vector reports the pin levels captured just after reset.
// RULE10: Each indicator has a polarity bit, zero meaning active low and one active high.
// RULE11: Indicator C is driven with its value bit while its force bit is set.
// RULE12: Indicator B is driven with its value bit while its force bit is set.
// RULE13: Indicator A is driven with its value bit while its force bit is set.
// RULE14: Reserved selector codes and missing clock codes hold the pin low.
module pom_pin_mux (
    input  wire logic                          mclk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic [15:0]                   avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [31:0]                   avs_writedata_in,
    input  wire logic [3:0]                    avs_byteenable_in,
    output logic      [31:0]                   avs_readdata_out,
    output logic                               avs_waitrequest_out,
    input  wire logic [pom_pkg::POM_CLK_SRCS-1:0] clk_src_in,
    input  wire logic                          irq_in,
    input  wire logic                          ind_a_act_in,
    input  wire logic                          ind_b_act_in,
    input  wire logic                          ind_c_act_in,
    input  wire logic [pom_pkg::POM_STRAP_W-1:0] strap_pins_in,
    input  wire logic                          ind_c_pin_in,
    output logic                               ind_c_pin_out,
    output logic                               ind_c_pin_oe_out,
    output logic                               ind_a_pin_out,
    output logic                               gpio_pin_out,
    output logic                               clk_o_pin_out,
    output logic                               txerr_reuse_enable_out,
    output logic                               mii_tx_err_out
);

    typedef struct packed {
        logic [15:0]                     mux_ctrl;
        logic [15:0]                     ind_cfg;
        logic [pom_pkg::POM_STRAP_W-1:0] strap;
        logic                            strap_done;
        logic                            wait_req;
        logic [15:0]                     rdata;
        logic                            src_prev;
        logic                            div;
        logic                            gpio;
        logic                            clk_o;
        logic                            ind_a;
        logic                            ind_c;
        logic                            ind_c_oe;
        logic                            reuse;
        logic                            txerr;
    } pom_state_type;

    pom_state_type st_q;
    pom_state_type st_d;

    logic [2:0]  gp_sel;
    logic [2:0]  co_sel;
    logic [2:0]  gp_src;
    logic [3:0]  co_src;
    logic        gp_ok;
    logic        co_ok;
    logic        gp_clk;
    logic        co_raw;
    logic        co_clk;
    logic        co_div_en;
    logic        co_inv_en;
    logic        ind_a_v;
    logic        ind_b_v;
    logic        ind_c_v;
    logic        reuse_en;
    logic [13:0] bus_idx;
    logic        bus_req;
    logic [15:0] rd_val;

    assign gp_sel    = st_q.mux_ctrl[pom_pkg::POM_GP_SEL_LSB +: 3];
    assign co_sel    = st_q.mux_ctrl[pom_pkg::POM_CO_SEL_LSB +: 3];
    assign gp_src    = st_q.mux_ctrl[pom_pkg::POM_GP_SRC_LSB +: 3];
    assign co_src    = st_q.mux_ctrl[pom_pkg::POM_CO_SRC_LSB +: 4];
    assign co_div_en = st_q.mux_ctrl[pom_pkg::POM_CO_DIV_BIT];
    assign co_inv_en = st_q.mux_ctrl[pom_pkg::POM_CO_INV_BIT];
    assign reuse_en  = st_q.mux_ctrl[pom_pkg::POM_TXERR_BIT];
    assign bus_idx   = avs_address_in[15:pom_pkg::POM_IDX_LSB];
    assign bus_req   = avs_read_in | avs_write_in;

    // Clock selection; missing codes give a quiet low, not a stray source
    assign gp_ok  = pom_pkg::POM_CLK_VALID[{1'b0, gp_src}];  // see RULE14
    assign co_ok  = pom_pkg::POM_CLK_VALID[co_src];          // see RULE14
    assign gp_clk = gp_ok & clk_src_in[{1'b0, gp_src}];      // see RULE3
    assign co_raw = co_ok & clk_src_in[co_src];              // see RULE4 RULE5
    // Inversion is applied only to a real source so a bad code stays low
    assign co_clk = co_ok & ((co_div_en ? st_q.div : co_raw) ^ co_inv_en); // see RULE6 RULE7

    // Forced value wins; otherwise polarity sets the active level
    assign ind_a_v = st_q.ind_cfg[pom_pkg::POM_A_FRC_BIT] ? st_q.ind_cfg[pom_pkg::POM_A_VAL_BIT]
                   : ~(ind_a_act_in ^ st_q.ind_cfg[pom_pkg::POM_A_POL_BIT]); // see RULE10 RULE13
    assign ind_b_v = st_q.ind_cfg[pom_pkg::POM_B_FRC_BIT] ? st_q.ind_cfg[pom_pkg::POM_B_VAL_BIT]
                   : ~(ind_b_act_in ^ st_q.ind_cfg[pom_pkg::POM_B_POL_BIT]); // see RULE10 RULE12
    assign ind_c_v = st_q.ind_cfg[pom_pkg::POM_C_FRC_BIT] ? st_q.ind_cfg[pom_pkg::POM_C_VAL_BIT]
                   : ~(ind_c_act_in ^ st_q.ind_cfg[pom_pkg::POM_C_POL_BIT]); // see RULE10 RULE11

    function automatic logic pin_pick(input logic [2:0] sel,
                                      input logic       ind,
                                      input logic       clk,
                                      input logic       irq);
        logic v;
        v = 1'b0;
        unique case (sel)
            pom_pkg::POM_SEL_IND:    v = ind;
            pom_pkg::POM_SEL_CLK:    v = clk;
            pom_pkg::POM_SEL_IRQ:    v = irq;
            pom_pkg::POM_SEL_CONST1: v = 1'b1;
            default:                 v = 1'b0;  // Zero, constant zero, reserved
        endcase
        return v;
    endfunction

    always_comb begin
        unique case (bus_idx)
            pom_pkg::POM_IDX_MUX_CTRL: rd_val = st_q.mux_ctrl;
            pom_pkg::POM_IDX_STRAP_LO: rd_val = {6'h00, st_q.strap};       // see RULE9
            pom_pkg::POM_IDX_STRAP_HI: rd_val = pom_pkg::POM_ZERO16;
            pom_pkg::POM_IDX_IND_CFG:  rd_val = st_q.ind_cfg;
            default:                   rd_val = pom_pkg::POM_ZERO16;
        endcase
    end

    always_comb begin
        st_d = st_q;
        // Straps are caught once, on the first edge after reset release
        if (!st_q.strap_done) begin
            st_d.strap      = strap_pins_in;  // see RULE9
            st_d.strap_done = 1'b1;
        end
        // One wait cycle per access; the write lands at the edge that ends it
        st_d.wait_req = 1'b1;
        if (bus_req && st_q.wait_req) begin
            st_d.wait_req = 1'b0;
            st_d.rdata    = rd_val;
        end
        if (avs_write_in && !st_q.wait_req) begin
            if (bus_idx == pom_pkg::POM_IDX_MUX_CTRL) begin
                if (avs_byteenable_in[0]) begin
                    st_d.mux_ctrl[7:0] = avs_writedata_in[7:0];
                end
                if (avs_byteenable_in[1]) begin
                    st_d.mux_ctrl[15:8] = avs_writedata_in[15:8];
                end
            end
            if (bus_idx == pom_pkg::POM_IDX_IND_CFG) begin
                if (avs_byteenable_in[0]) begin
                    st_d.ind_cfg[7:0] = avs_writedata_in[7:0] & pom_pkg::POM_IND_CFG_MASK[7:0];
                end
                if (avs_byteenable_in[1]) begin
                    st_d.ind_cfg[15:8] = avs_writedata_in[15:8] & pom_pkg::POM_IND_CFG_MASK[15:8];
                end
            end
        end
        // Halving toggles on each sampled rise; sources near mclk rate alias
        st_d.src_prev = co_raw;
        if (co_raw && !st_q.src_prev) begin
            st_d.div = ~st_q.div;  // see RULE6
        end
        st_d.gpio  = pin_pick(gp_sel, ind_b_v, gp_clk, irq_in);  // see RULE1 RULE14
        st_d.clk_o = pin_pick(co_sel, ind_b_v, co_clk, irq_in);  // see RULE2 RULE14
        st_d.ind_a = ind_a_v;
        st_d.reuse = reuse_en;
        if (reuse_en) begin
            st_d.ind_c_oe = 1'b0;  // see RULE8
            st_d.ind_c    = 1'b0;
            st_d.txerr    = ind_c_pin_in;
        end else begin
            st_d.ind_c_oe = 1'b1;
            st_d.ind_c    = ind_c_v;
            st_d.txerr    = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_q            <= '0;
            st_q.mux_ctrl   <= pom_pkg::POM_MUX_CTRL_RST;
            st_q.ind_cfg    <= pom_pkg::POM_IND_CFG_RST;
            st_q.wait_req   <= 1'b1;
            st_q.ind_c_oe   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata_out       = {pom_pkg::POM_ZERO16, st_q.rdata};
    assign avs_waitrequest_out    = st_q.wait_req;
    assign gpio_pin_out           = st_q.gpio;
    assign clk_o_pin_out          = st_q.clk_o;
    assign ind_a_pin_out          = st_q.ind_a;
    assign ind_c_pin_out          = st_q.ind_c;
    assign ind_c_pin_oe_out       = st_q.ind_c_oe;
    assign txerr_reuse_enable_out = st_q.reuse;
    assign mii_tx_err_out         = st_q.txerr;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_co_clk_plain;
        co_sel == pom_pkg::POM_SEL_CLK && co_ok && !co_div_en && !co_inv_en;
    endsequence
    sequence s_co_clk_half;
        co_sel == pom_pkg::POM_SEL_CLK && co_ok && co_div_en && !co_inv_en;
    endsequence

    property p_gpio_const1;
        gp_sel == pom_pkg::POM_SEL_CONST1 |=> gpio_pin_out;
    endproperty
    a_gpio_const1: assert property (p_gpio_const1) // see RULE1
        else $error("gpio not high for constant one");

    property p_gpio_reserved;
        gp_sel == 3'h4 || gp_sel == 3'h5 || gp_sel == pom_pkg::POM_SEL_ZERO |=> !gpio_pin_out;
    endproperty
    a_gpio_reserved: assert property (p_gpio_reserved) // see RULE14
        else $error("gpio not low for zero code");

    property p_co_irq;
        co_sel == pom_pkg::POM_SEL_IRQ |=> clk_o_pin_out == $past(irq_in);
    endproperty
    a_co_irq: assert property (p_co_irq) // see RULE2
        else $error("clock pin not showing interrupt");

    property p_gpio_clk;
        gp_sel == pom_pkg::POM_SEL_CLK |=> gpio_pin_out == $past(gp_clk);
    endproperty
    a_gpio_clk: assert property (p_gpio_clk) // see RULE3
        else $error("gpio clock source wrong");

    property p_co_common;
        s_co_clk_plain and (co_src <= pom_pkg::POM_CLK_LAST_COMMON)
            |=> clk_o_pin_out == $past(clk_src_in[co_src]);
    endproperty
    a_co_common: assert property (p_co_common) // see RULE4
        else $error("clock pin common source wrong");

    property p_co_extra;
        s_co_clk_plain and (co_src > pom_pkg::POM_CLK_LAST_COMMON) |=> clk_o_pin_out == $past(co_raw);
    endproperty
    a_co_extra: assert property (p_co_extra) // see RULE5
        else $error("clock pin extra source wrong");

    property p_co_half;
        (s_co_clk_half and (co_raw && !st_q.src_prev)) ##1 s_co_clk_half
            |=> clk_o_pin_out == !$past(st_q.div, 2);
    endproperty
    a_co_half: assert property (p_co_half) // see RULE6
        else $error("halved clock did not toggle");

    property p_co_inv;
        co_sel == pom_pkg::POM_SEL_CLK && co_ok && !co_div_en && co_inv_en
            |=> clk_o_pin_out == !$past(co_raw);
    endproperty
    a_co_inv: assert property (p_co_inv) // see RULE7
        else $error("clock pin not inverted");

    property p_txerr_reuse;
        reuse_en |=> !ind_c_pin_oe_out && mii_tx_err_out == $past(ind_c_pin_in);
    endproperty
    a_txerr_reuse: assert property (p_txerr_reuse) // see RULE8
        else $error("transmit error reuse wrong");

    property p_strap;
        !st_q.strap_done |=> st_q.strap_done && st_q.strap == $past(strap_pins_in) ##1 $stable(st_q.strap);
    endproperty
    a_strap: assert property (p_strap) // see RULE9
        else $error("strap capture wrong");

    property p_ind_a_pol;
        !st_q.ind_cfg[pom_pkg::POM_A_FRC_BIT]
            |=> ind_a_pin_out == ($past(ind_a_act_in) == $past(st_q.ind_cfg[pom_pkg::POM_A_POL_BIT]));
    endproperty
    a_ind_a_pol: assert property (p_ind_a_pol) // see RULE10
        else $error("indicator A polarity wrong");

    property p_ind_c_force;
        st_q.ind_cfg[pom_pkg::POM_C_FRC_BIT] && !reuse_en
            |=> ind_c_pin_oe_out && ind_c_pin_out == $past(st_q.ind_cfg[pom_pkg::POM_C_VAL_BIT]);
    endproperty
    a_ind_c_force: assert property (p_ind_c_force) // see RULE11
        else $error("indicator C force wrong");

    property p_ind_b_force;
        st_q.ind_cfg[pom_pkg::POM_B_FRC_BIT] && gp_sel == pom_pkg::POM_SEL_IND
            |=> gpio_pin_out == $past(st_q.ind_cfg[pom_pkg::POM_B_VAL_BIT]);
    endproperty
    a_ind_b_force: assert property (p_ind_b_force) // see RULE12
        else $error("indicator B force wrong");

    property p_ind_a_force;
        st_q.ind_cfg[pom_pkg::POM_A_FRC_BIT]
            |=> ind_a_pin_out == $past(st_q.ind_cfg[pom_pkg::POM_A_VAL_BIT]);
    endproperty
    a_ind_a_force: assert property (p_ind_a_force) // see RULE13
        else $error("indicator A force wrong");

    property p_co_badcode;
        co_sel == pom_pkg::POM_SEL_CLK && !co_ok |=> !clk_o_pin_out;
    endproperty
    a_co_badcode: assert property (p_co_badcode) // see RULE14
        else $error("clock pin moved on missing code");

    property p_gpio_irq;
        gp_sel == pom_pkg::POM_SEL_IRQ |=> gpio_pin_out == $past(irq_in);
    endproperty
    a_gpio_irq: assert property (p_gpio_irq) // see RULE1
        else $error("gpio not showing interrupt");

    property p_co_const0;
        co_sel == pom_pkg::POM_SEL_ZERO || co_sel == pom_pkg::POM_SEL_CONST0 |=> !clk_o_pin_out;
    endproperty
    a_co_const0: assert property (p_co_const0) // see RULE2
        else $error("clock pin not low for zero code");

    property p_reuse_off;
        !reuse_en |=> ind_c_pin_oe_out && !mii_tx_err_out;
    endproperty
    a_reuse_off: assert property (p_reuse_off) // see RULE8
        else $error("indicator C pin not driven");

    property p_bus_ack;
        bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");

endmodule

`default_nettype wire

/* pom_far_side.sv */
// Far-side model: strap resistors and the shared indicator C pin wire.
// Assumes the bench supplies the MAC transmit-error level in the MAC's place.
`timescale 1ns/10ps
`default_nettype none
module pom_far_side #(
    parameter logic [9:0] STRAP_VALUE = 10'h2A5
) (
    input  wire logic       dut_pin_in,
    input  wire logic       dut_oe_in,
    input  wire logic       mac_tx_err_in,
    output logic [9:0]      strap_pins_out,
    output logic            wire_level_out
);
    // Alternating levels except bits 4 and 3, both low, so a swap of any other adjacent pair shows up
    assign strap_pins_out = STRAP_VALUE;
    // The MAC only gets the wire once the device has let go of it
    assign wire_level_out = dut_oe_in ? dut_pin_in : mac_tx_err_in;
endmodule
`default_nettype wire

/* tb_pom_pin_mux.sv */
// Self-checking bench for the pin output multiplexer.
// Assumes the design answers every bus access after one wait cycle.
`timescale 1ns/10ps
`default_nettype none
module tb_pom_pin_mux;
    localparam logic [9:0]  STRAPS = 10'h2A5;
    localparam logic [15:0] A_MUX  = 16'h118C;
    localparam logic [15:0] A_SLO  = 16'h119C;
    localparam logic [15:0] A_SHI  = 16'h11A0;
    localparam logic [15:0] A_CFG  = 16'h11A4;
    localparam logic [15:0] A_NONE = 16'h1190;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [15:0] adr = 16'h0000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0]  be = 4'hF;
    logic [15:0] csrc = 16'h0000;
    logic        irq = 1'b0;
    logic [2:0]  act = 3'h0;
    logic        mac_err = 1'b0;
    logic [31:0] rdat;
    wire logic [31:0] rdata;
    wire logic [9:0]  straps;
    wire logic        bwait, c_o, c_oe, a_o, gp_o, co_o, reuse_o, txe_o, c_wire;
    int n_fail = 0;
    int num_checks = 0;

    pom_pin_mux DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(bwait), .clk_src_in(csrc),
        .irq_in(irq), .ind_a_act_in(act[0]), .ind_b_act_in(act[1]), .ind_c_act_in(act[2]),
        .strap_pins_in(straps), .ind_c_pin_in(c_wire), .ind_c_pin_out(c_o),
        .ind_c_pin_oe_out(c_oe), .ind_a_pin_out(a_o), .gpio_pin_out(gp_o),
        .clk_o_pin_out(co_o), .txerr_reuse_enable_out(reuse_o), .mii_tx_err_out(txe_o));
    pom_far_side #(.STRAP_VALUE(STRAPS)) far (.dut_pin_in(c_o), .dut_oe_in(c_oe),
        .mac_tx_err_in(mac_err), .strap_pins_out(straps), .wire_level_out(c_wire));

    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic is_rd, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] en);
        int n;
        n = 0;
        @(posedge mclk_in);
        adr <= a;
        wdat <= d;
        be <= en;
        rd <= is_rd;
        wr <= !is_rd;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (bwait !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_fail++;
            $display("ERROR bus answer missing");
        end
        @(posedge mclk_in);
        rdat = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wt();
        repeat (4) @(posedge mclk_in);
        #1;
    endtask

    task automatic wset(input logic [15:0] a, input logic [15:0] d);
        bus(1'b0, a, {16'h0000, d}, 4'hF);
        wt();
    endtask

    task automatic ins(input logic [15:0] c, input logic i, input logic [2:0] a);
        @(posedge mclk_in);
        csrc <= c;
        irq <= i;
        act <= a;
    endtask

    task automatic t_regs();
        bus(1'b1, A_MUX, 32'h0000_0000, 4'hF);
        chk("mux_reset", rdat, 32'h0000_0000);
        bus(1'b1, A_CFG, 32'h0000_0000, 4'hF);
        chk("cfg_reset", rdat, 32'h0000_0000);
        bus(1'b0, A_SLO, 32'h0000_FFFF, 4'hF);
        bus(1'b1, A_SLO, 32'h0000_0000, 4'hF);
        chk("strap_low", rdat, {22'h00_0000, STRAPS});
        bus(1'b1, A_SHI, 32'h0000_0000, 4'hF);
        chk("strap_high", rdat, 32'h0000_0000);
        bus(1'b0, A_NONE, 32'h0000_FFFF, 4'hF);
        bus(1'b1, A_NONE, 32'h0000_0000, 4'hF);
        chk("unmapped", rdat, 32'h0000_0000);
        bus(1'b0, A_CFG, 32'h0000_FFFF, 4'hF);
        bus(1'b1, A_CFG, 32'h0000_0000, 4'hF);
        chk("cfg_mask", rdat, 32'h0000_0777);
        bus(1'b0, A_MUX, 32'h0000_FFFF, 4'h1);
        bus(1'b0, A_MUX, 32'h0000_0000, 4'h2);
        bus(1'b1, A_MUX, 32'h0000_0000, 4'hF);
        chk("mux_lanes", rdat, 32'h0000_00FF);
        wset(A_MUX, 16'h0000);
    endtask

    task automatic t_sel();
        logic [2:0] p;
        logic       e;
        wset(A_CFG, 16'h0040);
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 3; k++) begin
                p = 3'h1 << k;
                ins({15'h0000, p[1]}, p[2], {1'b0, p[0], 1'b0});
                wset(A_MUX, {3'h0, s[2:0], 6'h00, 1'b0, s[2:0]});
                e = (s == 0) ? p[0] : (s == 1) ? p[1] : (s == 2) ? p[2] : (s == 7);
                chk("gpio_sel", gp_o, e);
                chk("clko_sel", co_o, e);
            end
        end
    endtask

    task automatic t_src();
        for (int c = 0; c < 16; c++) begin
            ins(16'h0001 << c, 1'b0, 3'h0);
            wset(A_MUX, {c[2:0], 3'h1, 2'h0, c[3:0], 1'b0, 3'h1});
            chk("clko_src", co_o, c <= 6 || (c >= 8 && c <= 12));
            if (c < 8) chk("gpio_src", gp_o, c <= 6);
        end
        ins(16'h0001, 1'b0, 3'h0);
        wset(A_MUX, 16'h0009);
        chk("clko_inv_hi", co_o, 1'b0);
        ins(16'h0000, 1'b0, 3'h0);
        wt();
        chk("clko_inv_lo", co_o, 1'b1);
        wset(A_MUX, 16'h0079);
        chk("clko_inv_gap", co_o, 1'b0);
    endtask

    // Source toggles every cycle, so full rate gives 32 output edges in 32 cycles
    task automatic toggles(output int n);
        logic prev;
        n = 0;
        prev = co_o;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk_in);
            csrc <= {15'h0000, ~csrc[0]};
            #1;
            if (i >= 8 && co_o !== prev) n++;
            prev = co_o;
        end
    endtask

    task automatic t_div();
        int n;
        wset(A_MUX, 16'h0101);
        toggles(n);
        chk("clko_half", n >= 15 && n <= 17, 1'b1);
        wset(A_MUX, 16'h0001);
        toggles(n);
        chk("clko_full", n >= 31 && n <= 33, 1'b1);
    endtask

    task automatic t_ind();
        logic [15:0] cfgs [6] = '{16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0007, 16'h0005};
        logic [5:0]  av = 6'b100101;
        logic [5:0]  ev = 6'b010110;
        wset(A_MUX, 16'h0000);
        for (int r = 0; r < 6; r++) begin
            ins(16'h0000, 1'b0, {3{av[r]}});
            wset(A_CFG, cfgs[r] | (cfgs[r] << 4) | (cfgs[r] << 8));
            chk("ind_a", a_o, ev[r]);
            chk("ind_b", gp_o, ev[r]);
            chk("ind_c", c_o, ev[r]);
            chk("ind_c_oe", c_oe, 1'b1);
        end
    endtask

    task automatic t_txerr();
        wset(A_MUX, 16'h0200);
        chk("reuse_oe", c_oe, 1'b0);
        chk("reuse_flag", reuse_o, 1'b1);
        for (int v = 1; v >= 0; v--) begin
            @(posedge mclk_in);
            mac_err <= v[0];
            wt();
            chk("tx_err", txe_o, v[0]);
        end
        @(posedge mclk_in);
        mac_err <= 1'b1;
        wset(A_MUX, 16'h0000);
        chk("reuse_off_oe", c_oe, 1'b1);
        chk("reuse_off_err", txe_o, 1'b0);
        chk("reuse_off_flag", reuse_o, 1'b0);
        @(posedge mclk_in);
        mac_err <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_sel();
        t_src();
        t_div();
        t_ind();
        t_txerr();
        wrap_up();
    end

    // Scenarios need about six hundred cycles; fifty times that means a hang
    initial begin
        repeat (30000) @(posedge mclk_in);
        n_fail++;
        $display("ERROR watchdog expired");
        wrap_up();
    end
endmodule
`default_nettype wire
